// ### common/gst_pkg.sv
// Package of constants and types for the gated sixteen bit timer.
// Functional notes
// - Two-bit field selects counter clock source.
// - Internal source increments per prescaled period.
// - External pin counts on rising edges.
// - External mode needs falling edge first.
// - Choosing slow oscillator forces it on.
// - Prescaler divides by one, two, four, eight.
// - Prescaler hidden; cleared by counter writes.
// - Sync-disable bit only lets pin edges count during sleep.
// - Asynchronous external mode counts during sleep.
// - Mode switch may lose or add one; here it neither drops nor adds an edge.
// - Counter byte reads always return valid.
// - Gate used only when enabled; polarity bit.
// - Active gate lets clock edges increment.
// - Inactive gate holds the count.
// - Two-bit field selects gate source.
// - Timer zero wrap gives one gate pulse.
// - Toggle mode flips gate per rising edge.
// - Toggle flip-flop held clear when disabled.
// - Run bit off, free, or gated counting.
// - Counter byte writes update count immediately.
// - Counter wraps to zero and sets flag.
package gst_pkg;
	// ==========================================================
	// Register map
	localparam logic [11:0] ADDR_TIMER_CONTROL = 12'h000;
	localparam logic [11:0] ADDR_GATE_CONTROL = 12'h004;
	localparam logic [11:0] ADDR_COUNT_LOW = 12'h008;
	localparam logic [11:0] ADDR_COUNT_HIGH = 12'h00C;
	localparam logic [11:0] ADDR_STATUS = 12'h010;
	// ==========================================================
	// Timer control field positions.
	localparam int TC_RUN = 0;
	localparam int TC_SYNC_DIS = 2;
	localparam int TC_PRESCALE_LO = 4;
	localparam int TC_SOURCE_LO = 6;
	// Gate control field positions.
	localparam int GC_SOURCE_LO = 0;
	localparam int GC_TOGGLE = 5;
	localparam int GC_POLARITY = 6;
	localparam int GC_ENABLE = 7;
	// Status field positions.
	localparam int ST_OVERFLOW = 0;
	localparam int ST_OSC_FORCE = 1;
	// ==========================================================
	// Reset values and limits.
	localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
	localparam logic [7:0] GATE_CONTROL_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [7:0] TIMER_ZERO_MAX = 8'hFF;
	localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
	// ==========================================================
	// Clock source codes.
	typedef enum logic [1:0]
	{
		GST_CLK_INSTR = 2'h0,
		GST_CLK_SYSTEM = 2'h1,
		GST_CLK_PIN = 2'h2,
		GST_CLK_SLOW_OSC = 2'h3
	} gst_clk_src_t;
	// Gate source codes.
	typedef enum logic [1:0]
	{
		GST_GATE_PIN = 2'h0,
		GST_GATE_TIMER_ZERO = 2'h1,
		GST_GATE_COMP_ONE = 2'h2,
		GST_GATE_COMP_TWO = 2'h3
	} gst_gate_src_t;
	// External asynchronous inputs carried together.
	typedef struct packed
	{
		logic count_clock;
		logic gate_pin;
		logic comp_one;
		logic comp_two;
		logic slow_osc;
	} gst_ext_t;
endpackage

// ### test/gst_far_side.sv
// Model of the pins, comparators and timer zero around the timer.
`timescale 1ns/100ps
`default_nettype none
module gst_far_side
(
	// Clock of the timer.
	input wire logic pclk,
	// Levels seen by the timer.
	output var gst_pkg::gst_ext_t ext,
	output var logic [7:0] t0
);
	// ===
	// Timer zero runs only when the bench asks for it.
	logic t0_run = 1'b0;
	logic [2:0] osc_div = 3'h0;
	initial
	begin
		ext = '0;
		t0 = 8'h0;
	end
	// The slow oscillator runs free with a sixteen cycle period.
	always @(posedge pclk)
	begin
		osc_div <= osc_div + 3'h1;
		if (osc_div == 3'h7)
			ext.slow_osc <= !ext.slow_osc;
		if (t0_run)
			t0 <= t0 + 8'h1;
	end
	// Clock pin pulses, each level held for half cycles.
	task automatic pulses(input int n, input int half);
		repeat (n)
		begin
			repeat (half) @(posedge pclk);
			ext.count_clock <= 1'b1;
			repeat (half) @(posedge pclk);
			ext.count_clock <= 1'b0;
		end
	endtask
	// One high pulse on the gate pin.
	task automatic gate_pulse(input int hi);
	begin
		@(posedge pclk);
		ext.gate_pin <= 1'b1;
		repeat (hi) @(posedge pclk);
		ext.gate_pin <= 1'b0;
	end
	endtask
endmodule
`default_nettype wire

// ### test/gst_timer_monitor.sv
// Port checker of the gated timer, bound to its top module.
`timescale 1ns/100ps
`default_nettype none
module gst_timer_monitor
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Bus and status ports.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic overflow_flag,
	input wire logic slow_osc_force_on
);
	// ===
	// Decoded access, bad address, control write and flag clear.
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic acc = psel && penable;
	wire logic bad = paddr > 12'h10 || paddr[1:0] != 2'h0;
	wire logic cwr = acc && pwrite && paddr == 12'h0;
	wire logic clr = acc && pwrite && paddr == 12'h10 && pwdata[0];
	logic clr_q;
	// A clear reaches the flag output one edge after the write.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			clr_q <= 1'b0;
		else
			clr_q <= clr;
	end
	ready_in_access_a: assert property (acc |-> pready) else $error("late ready");
	bad_addr_err_a: assert property (acc && bad |-> pslverr) else $error("no refusal");
	good_addr_ok_a: assert property (acc && !bad |-> !pslverr) else $error("false refusal");
	count_byte_only_a: assert property (acc && !pwrite && (paddr == 12'h8 || paddr == 12'hC)
		|-> prdata[31:8] == 24'h0) else $error("wide count byte");
	osc_forced_on_a: assert property (cwr && pwdata[7:6] == 2'h3 |-> ##2 slow_osc_force_on)
		else $error("oscillator not forced");
	osc_released_a: assert property (cwr && pwdata[7:6] != 2'h3 |-> ##2 !slow_osc_force_on)
		else $error("oscillator still forced");
	osc_force_hold_a: assert property (!cwr && !$past(cwr) |=> $stable(slow_osc_force_on))
		else $error("oscillator force moved");
	overflow_sticky_a: assert property (overflow_flag && !clr && !clr_q |=> overflow_flag)
		else $error("overflow flag lost");
	cover property (acc && bad);
	cover property ($rose(overflow_flag));
	cover property ($rose(slow_osc_force_on));
endmodule
bind gst_timer gst_timer_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .overflow_flag, .slow_osc_force_on);
`default_nettype wire

// ### test/test_gst_timer.sv
// Self-checking bench of the gated timer.
`timescale 1ns/100ps
`default_nettype none
module test_gst_timer;
	// ===
	// Bus, pin and status signals.
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic slp = 1'b0;
	logic ovf;
	logic force_on;
	logic wake;
	logic err;
	logic [31:0] rd;
	gst_pkg::gst_ext_t ext;
	logic [7:0] t0;
	int fails = 0;
	int checked = 0;
	int cycles = 0;
	always #2.5 pclk = ~pclk;
	gst_timer uut (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .ext_in(ext), .eight_bit_timer_zero(t0), .sleep_mode(slp),
		.overflow_flag(ovf), .slow_osc_force_on(force_on), .wake_request(wake));
	gst_far_side far (.pclk, .ext, .t0);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	end
	endtask
	// One transfer, held until ready is seen at an edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
	begin
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	end
	endtask
	task automatic ctl(input logic [7:0] v);
		apb(1'b1, gst_pkg::ADDR_TIMER_CONTROL, {24'h0, v});
	endtask
	task automatic zero();
	begin
		apb(1'b1, gst_pkg::ADDR_COUNT_LOW, 32'h0);
		apb(1'b1, gst_pkg::ADDR_COUNT_HIGH, 32'h0);
	end
	endtask
	// Reads the low byte, then the high byte, and compares the pair.
	task automatic cnt(input logic [15:0] exp);
		logic [7:0] lo;
	begin
		apb(1'b0, gst_pkg::ADDR_COUNT_LOW, 32'h0);
		lo = rd[7:0];
		apb(1'b0, gst_pkg::ADDR_COUNT_HIGH, 32'h0);
		chk({16'h0, rd[7:0], lo}, {16'h0, exp});
	end
	endtask
	// Runs for d cycles between the start and stop writes.
	task automatic win(input logic [7:0] c, input int d, input logic [15:0] exp);
	begin
		zero();
		ctl(c | 8'h1);
		repeat (d - 3) @(posedge pclk);
		ctl(c);
		repeat (6) @(posedge pclk);
		cnt(exp);
	end
	endtask
	// Reset values read as zero; unmapped places are refused.
	task automatic regs();
	begin
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b0, 12'(i * 4), 32'h0);
			chk(rd, 32'h0);
			chk({31'h0, err}, 32'h0);
		end
		apb(1'b0, 12'h14, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, 12'h20, 32'h0);
		chk({31'h0, err}, 32'h1);
	end
	endtask
	// Every source and prescale over 64 cycles, except slow oscillator by eight; the pin stands still.
	task automatic sources();
		logic [15:0] base [4] = '{16'h10, 16'h40, 16'h0, 16'h4};
	begin
		for (int s = 0; s < 4; s++)
			for (int p = 0; p < 4; p++)
				if (s * 4 + p != 15)
					win({s[1:0], p[1:0], 4'h0}, 64, base[s] >> p);
		chk({31'h0, force_on}, 32'h1);
	end
	endtask
	// Wrap from the top, then clear the flag.
	task automatic rollover();
	begin
		apb(1'b1, gst_pkg::ADDR_COUNT_LOW, 32'hFE);
		apb(1'b1, gst_pkg::ADDR_COUNT_HIGH, 32'hFF);
		cnt(16'hFFFE);
		ctl(8'h41);
		repeat (5) @(posedge pclk);
		ctl(8'h40);
		cnt(16'h6);
		chk({31'h0, ovf}, 32'h1);
		// A pending overflow asks for a wake while the core sleeps.
		slp <= 1'b1;
		repeat (2) @(posedge pclk);
		chk({31'h0, wake}, 32'h1);
		slp <= 1'b0;
		apb(1'b1, gst_pkg::ADDR_STATUS, 32'h1);
		repeat (3) @(posedge pclk);
		chk({31'h0, ovf}, 32'h0);
		chk({31'h0, wake}, 32'h0);
	end
	endtask
	// Three pin pulses; the first rise after enabling is not counted.
	task automatic pin(input logic [7:0] c, input logic s, input logic [15:0] exp);
	begin
		zero();
		slp <= s;
		ctl(c | 8'h1);
		far.pulses(3, 4);
		repeat (6) @(posedge pclk);
		ctl(c);
		slp <= 1'b0;
		cnt(exp);
	end
	endtask
	// Gate modes and sources, then a toggle span of 23 cycles.
	task automatic gates();
		logic [7:0] gc [7] = '{8'h0, 8'h80, 8'hC0, 8'hC2, 8'hC3, 8'h83, 8'hC1};
		logic [15:0] ex [7] = '{16'h10, 16'h0, 16'h10, 16'h10, 16'h0, 16'h10, 16'h0};
	begin
		far.ext.gate_pin <= 1'b1;
		far.ext.comp_one <= 1'b1;
		for (int i = 0; i < 7; i++)
		begin
			apb(1'b1, gst_pkg::ADDR_GATE_CONTROL, {24'h0, gc[i]});
			win(8'h40, 16, ex[i]);
		end
		far.t0 <= 8'hF0;
		far.t0_run <= 1'b1;
		win(8'h40, 16, 16'h1);
		far.t0_run <= 1'b0;
		far.ext.gate_pin <= 1'b0;
		apb(1'b1, gst_pkg::ADDR_GATE_CONTROL, 32'hE0);
		zero();
		ctl(8'h41);
		far.gate_pulse(2);
		repeat (20) @(posedge pclk);
		far.gate_pulse(2);
		repeat (6) @(posedge pclk);
		ctl(8'h40);
		cnt(16'h17);
	end
	endtask
	task automatic summarize();
	begin
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
	endtask
	// A hang is cut short well beyond the expected run.
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			summarize();
		end
	end
	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		regs();
		sources();
		rollover();
		pin(8'h80, 1'b0, 16'h2);
		pin(8'h84, 1'b1, 16'h2);
		pin(8'h80, 1'b1, 16'h0);
		gates();
		summarize();
	end
endmodule
`default_nettype wire

// ### verilog/gst_timer.sv
// Gated sixteen bit timer with APB register access.
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module gst_timer
(
	// APB clock, reset and enable.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave port.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Asynchronous pins and comparator outputs.
	input wire gst_pkg::gst_ext_t ext_in,
	// Timer zero counter value from the same clock domain.
	input wire logic [7:0] eight_bit_timer_zero,
	// Sleep indication from the same clock domain.
	input wire logic sleep_mode,
	// Status outputs.
	output logic overflow_flag,
	output logic slow_osc_force_on,
	output logic wake_request
);
	// ==========================================================
	// Declarations
	logic [7:0] timer_control_reg_q;
	logic [7:0] gate_control_reg_q;
	logic [15:0] count_q;
	logic [2:0] prescale_q;
	logic overflow_q;
	logic [4:0] sync1_q;
	logic [4:0] sync2_q;
	logic [4:0] prev_q;
	logic [1:0] instr_div_q;
	logic [7:0] tz_prev_q;
	logic toggle_q;
	logic armed_q;
	logic tz_pulse;
	logic gate_raw;
	logic gate_val;
	logic gate_rise;
	logic gate_active;
	logic clk_tick;
	logic run;
	logic inc;
	logic prescale_done;
	logic wr_access;
	logic wr_low;
	logic wr_high;
	logic [2:0] prescale_last;
	gst_pkg::gst_clk_src_t clk_sel;
	gst_pkg::gst_gate_src_t gate_sel;
	logic [4:0] ext_now;

	// Decodes an APB address compare.
	function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] ref_addr);
		addr_hit = (a == ref_addr);
	endfunction

	// ==========================================================
	// Register writes
	assign wr_access = clk_en && psel && penable && pwrite;
	assign wr_low = wr_access && addr_hit(paddr, gst_pkg::ADDR_COUNT_LOW);
	assign wr_high = wr_access && addr_hit(paddr, gst_pkg::ADDR_COUNT_HIGH);
	assign clk_sel = gst_pkg::gst_clk_src_t'(timer_control_reg_q[gst_pkg::TC_SOURCE_LO +: 2]);
	assign gate_sel = gst_pkg::gst_gate_src_t'(gate_control_reg_q[gst_pkg::GC_SOURCE_LO +: 2]);
	assign run = timer_control_reg_q[gst_pkg::TC_RUN];

	// Control register writes from software.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			timer_control_reg_q <= gst_pkg::TIMER_CONTROL_RESET;
			gate_control_reg_q <= gst_pkg::GATE_CONTROL_RESET;
		end
		else if (wr_access && addr_hit(paddr, gst_pkg::ADDR_TIMER_CONTROL))
		begin
			timer_control_reg_q <= pwdata[7:0];
		end
		else if (wr_access && addr_hit(paddr, gst_pkg::ADDR_GATE_CONTROL))
		begin
			gate_control_reg_q <= pwdata[7:0];
		end
	end

	// ==========================================================
	// Synchronisers
	assign ext_now = ext_in;

	// Two flip-flops on every asynchronous input before use.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_q <= 5'h0;
			sync2_q <= 5'h0;
			prev_q <= 5'h0;
		end
		else if (clk_en)
		begin
			sync1_q <= ext_now;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	// The instruction clock is one tick in four system clocks.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			instr_div_q <= 2'h0;
		end
		else if (clk_en)
		begin
			instr_div_q <= instr_div_q + 2'h1;
		end
	end

	// ==========================================================
	// Clock source selection
	// Asynchronous mode differs only in letting pin edges count while
	// sleep_mode is high; pin edges are taken after the two-flop chain in both modes,
	// so a mode switch neither drops nor adds an edge.
	always_comb
	begin
		clk_tick = 1'b0;
		unique case (clk_sel)
			gst_pkg::GST_CLK_INSTR:
			begin
				clk_tick = (instr_div_q == gst_pkg::INSTR_DIV_LAST);
			end
			gst_pkg::GST_CLK_SYSTEM:
			begin
				clk_tick = 1'b1;
			end
			gst_pkg::GST_CLK_PIN:
			begin
				// Rising edge of the pin; synchronised mode does not count during sleep.
				clk_tick = sync2_q[4] && !prev_q[4] && armed_q
					&& (timer_control_reg_q[gst_pkg::TC_SYNC_DIS]
					|| !sleep_mode);
			end
			gst_pkg::GST_CLK_SLOW_OSC:
			begin
				clk_tick = sync2_q[0] && !prev_q[0];
			end
		endcase
	end

	// A falling pin edge must be seen before counting restarts.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			armed_q <= 1'b0;
		end
		else if (clk_en)
		begin
			if (!run || wr_low || wr_high)
			begin
				armed_q <= 1'b0;
			end
			else if (!sync2_q[4] && prev_q[4])
			begin
				armed_q <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Gate logic
	// Timer zero wrap seen as a single pulse.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tz_prev_q <= 8'h00;
		end
		else if (clk_en)
		begin
			tz_prev_q <= eight_bit_timer_zero;
		end
	end
	assign tz_pulse = (tz_prev_q == gst_pkg::TIMER_ZERO_MAX) && (eight_bit_timer_zero == 8'h00);

	// Gate source multiplexer.
	always_comb
	begin
		gate_raw = 1'b0;
		unique case (gate_sel)
			gst_pkg::GST_GATE_PIN: gate_raw = sync2_q[3];
			gst_pkg::GST_GATE_TIMER_ZERO: gate_raw = tz_pulse;
			gst_pkg::GST_GATE_COMP_ONE: gate_raw = sync2_q[2];
			gst_pkg::GST_GATE_COMP_TWO: gate_raw = sync2_q[1];
		endcase
	end

	// Rising edge of the selected gate source for toggle mode.
	logic gate_raw_prev_q;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gate_raw_prev_q <= 1'b0;
		end
		else if (clk_en)
		begin
			gate_raw_prev_q <= gate_raw;
		end
	end
	assign gate_rise = gate_raw && !gate_raw_prev_q;

	// Toggle flip-flop, held clear while toggle mode is off.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			toggle_q <= 1'b0;
		end
		else if (clk_en)
		begin
			if (!gate_control_reg_q[gst_pkg::GC_TOGGLE])
			begin
				toggle_q <= 1'b0;
			end
			else if (gate_rise)
			begin
				toggle_q <= !toggle_q;
			end
		end
	end

	// Polarity and enable decide whether counting is allowed.
	assign gate_val = gate_control_reg_q[gst_pkg::GC_TOGGLE] ? toggle_q : gate_raw;
	assign gate_active = !gate_control_reg_q[gst_pkg::GC_ENABLE]
		|| (gate_val == gate_control_reg_q[gst_pkg::GC_POLARITY]);

	// ==========================================================
	// Prescaler and counter
	assign prescale_last = 3'((4'h1 << timer_control_reg_q[gst_pkg::TC_PRESCALE_LO +: 2]) - 4'h1);
	assign prescale_done = (prescale_q == prescale_last);
	assign inc = run && gate_active && clk_tick;

	// Hidden prescale counter, cleared by any counter write.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prescale_q <= 3'h0;
		end
		else if (clk_en)
		begin
			if (wr_low || wr_high)
			begin
				prescale_q <= 3'h0;
			end
			else if (inc)
			begin
				prescale_q <= prescale_done ? 3'h0 : prescale_q + 3'h1;
			end
		end
	end

	// The counter itself; a software write wins over an increment.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count_q <= gst_pkg::COUNT_RESET;
		end
		else if (clk_en)
		begin
			if (wr_low)
			begin
				count_q[7:0] <= pwdata[7:0];
			end
			else if (wr_high)
			begin
				count_q[15:8] <= pwdata[7:0];
			end
			else if (inc && prescale_done)
			begin
				count_q <= count_q + 16'h0001;
			end
		end
	end

	// Overflow flag; set wins over a software clear.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			overflow_q <= 1'b0;
		end
		else if (clk_en)
		begin
			if (inc && prescale_done && !wr_low && !wr_high && count_q == gst_pkg::COUNT_MAX)
			begin
				overflow_q <= 1'b1;
			end
			else if (wr_access && addr_hit(paddr, gst_pkg::ADDR_STATUS) && pwdata[gst_pkg::ST_OVERFLOW])
			begin
				overflow_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Outputs and read data
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			overflow_flag <= 1'b0;
			slow_osc_force_on <= 1'b0;
			wake_request <= 1'b0;
		end
		else if (clk_en)
		begin
			overflow_flag <= overflow_q;
			slow_osc_force_on <= (clk_sel == gst_pkg::GST_CLK_SLOW_OSC);
			wake_request <= overflow_q && sleep_mode;
		end
	end

	// Read data is registered in the setup cycle; pready is high from the first enabled edge after reset.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
			pready <= 1'b0;
		end
		else if (clk_en)
		begin
			pready <= 1'b1;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (psel && !penable)
			begin
				if (addr_hit(paddr, gst_pkg::ADDR_TIMER_CONTROL))
					prdata <= {24'h00_0000, timer_control_reg_q};
				else if (addr_hit(paddr, gst_pkg::ADDR_GATE_CONTROL))
					prdata <= {24'h00_0000, gate_control_reg_q};
				else if (addr_hit(paddr, gst_pkg::ADDR_COUNT_LOW))
					prdata <= {24'h00_0000, count_q[7:0]};
				else if (addr_hit(paddr, gst_pkg::ADDR_COUNT_HIGH))
					prdata <= {24'h00_0000, count_q[15:8]};
				else if (addr_hit(paddr, gst_pkg::ADDR_STATUS))
					prdata <= {30'h0000_0000, slow_osc_force_on, overflow_q};
				else
					pslverr <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire
